// ### src/atsh_consts.vh
/*
 * Constants for the two-step converter host controller: register offsets,
 * field positions, reset values and pin timing counts.
 * Assumes a 250 MHz controller clock (4 ns period).
 */
`ifndef ATSH_CONSTS_VH
`define ATSH_CONSTS_VH

`define ATSH_CLK_PERIOD_NS   4

// Register byte offsets
`define ATSH_REG_CTRL        8'h00
`define ATSH_REG_STATUS      8'h04
`define ATSH_REG_IRQ_STAT    8'h08
`define ATSH_REG_IRQ_MASK    8'h0C
`define ATSH_REG_RESULT      8'h10
`define ATSH_REG_ACQ         8'h14

// CTRL fields
`define ATSH_CTRL_START      0
`define ATSH_CTRL_MODE       1
`define ATSH_CTRL_RDSEL      3
`define ATSH_CTRL_RDSEL_W    2
`define ATSH_CTRL_RESET      32'h0000_0000

// Read style codes
`define ATSH_RD_INT          2'h0
`define ATSH_RD_EXT          2'h1
`define ATSH_RD_PIPE         2'h2
`define ATSH_RD_ALONE        2'h3

// STATUS fields
`define ATSH_ST_BUSY         0
`define ATSH_ST_RDY          1
`define ATSH_ST_EOC          2
`define ATSH_ST_OVF          3

// IRQ bits
`define ATSH_IRQ_DONE        0
`define ATSH_IRQ_OVF         1
`define ATSH_IRQ_W           2

// Timing in ns, as printed
`define ATSH_T_ACQ_NS        600
`define ATSH_T_EXTRD_NS      600
`define ATSH_T_EOC_NS        700
`define ATSH_T_GAP_NS        500
`define ATSH_T_APER_NS       100
`define ATSH_T_ALONE_NS      700

// Least times round up to whole cycles
`define ATSH_CYC_MIN(ns) (((ns) + `ATSH_CLK_PERIOD_NS - 1) / `ATSH_CLK_PERIOD_NS)

`endif

// ### src/atsh_ahb_slave.v
/*
 * AHB-Lite register slave for the host controller.
 * Assumes a single master, single word transfers, zero wait states.
 */
`timescale 1ns/1ps
`default_nettype none
`include "atsh_consts.vh"

module atsh_ahb_slave (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // AHB-Lite
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // Register file side
  output reg         wr_o,
  output reg  [7:0]  wr_addr_o,
  output wire [31:0] wr_data_o,
  output reg  [7:0]  rd_addr_o,
  input  wire [31:0] rd_data_i
);

  reg rd_pend;

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign wr_data_o   = hwdata_i;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_o      <= 1'b0;
      wr_addr_o <= 8'h00;
      rd_addr_o <= 8'h00;
      rd_pend   <= 1'b0;
    end else begin
      wr_o    <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
      rd_pend <= hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
      if (hsel_i & hready_i & htrans_i[1]) begin
        wr_addr_o <= haddr_i[7:0];
        rd_addr_o <= haddr_i[7:0];
      end
    end
  end

  // Read data muxed combinationally in the data phase
  always @* begin
    hrdata_o = 32'h0000_0000;
    if (rd_pend)
      hrdata_o = rd_data_i;
  end

endmodule
`default_nettype wire

// ### src/atsh_pin_timer.v
/*
 * Down counter that reports when a programmed delay has expired.
 * Assumes load and count come from the controller sequencer.
 */
`timescale 1ns/1ps
`default_nettype none

module atsh_pin_timer #(
  parameter W = 12
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // Control
  input  wire         load_i,
  input  wire [W-1:0] value_i,
  output wire         done_o
);

  reg [W-1:0] cnt;

  assign done_o = (cnt == {W{1'b0}});

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      cnt <= {W{1'b0}};
    else if (load_i)
      cnt <= value_i;
    else if (!done_o)
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
  end

endmodule
`default_nettype wire

// ### src/atsh_host.v
/*
 * Host controller for an 8-bit two-step flash converter. Drives select,
 * read and write strobes and the mode pin, samples the result bus, ready,
 * end-of-conversion and overflow pins, and reports over AHB-Lite.
 * Assumes converter pins are synchronous to clk_i and settle within the
 * programmed delays.
 */
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "atsh_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Read-only: hold read strobe low until the result word appears.
// - Device drives data only while read and select are low; rise clears flag.
// - External read timing: read low no sooner than 600 ns after write rises.
// - Wait 500 ns after end flag falls before the next write strobe.
// - Write strobe held low at least 600 ns for acquisition.
module atsh_host #(
  parameter TW = 12
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // Interrupt
  output reg         irq_o,
  // Converter pins
  output reg         cs_n_o,
  output reg         rd_n_o,
  output reg         mode_o,
  output reg         wr_rdy_o,
  output reg         wr_rdy_oe_n_o,
  input  wire        wr_rdy_i,
  input  wire        eoc_n_i,
  input  wire        overflow_flag_i,
  input  wire [7:0]  result_bus_i
);

  // Cycle counts, cut to the timer width on purpose
  localparam integer N_ACQ   = `ATSH_CYC_MIN(`ATSH_T_ACQ_NS);
  localparam integer N_EXTRD = `ATSH_CYC_MIN(`ATSH_T_EXTRD_NS);
  localparam integer N_EOC   = `ATSH_CYC_MIN(`ATSH_T_EOC_NS);
  localparam integer N_GAP   = `ATSH_CYC_MIN(`ATSH_T_GAP_NS);
  // Pipelined end: flag delay plus setup before the next write
  localparam integer N_PIPE  = `ATSH_CYC_MIN(`ATSH_T_EOC_NS + `ATSH_T_GAP_NS);

  localparam [TW-1:0] C_ACQ   = N_ACQ[TW-1:0];
  localparam [TW-1:0] C_EXTRD = N_EXTRD[TW-1:0];
  localparam [TW-1:0] C_EOC   = N_EOC[TW-1:0];
  localparam [TW-1:0] C_GAP   = N_GAP[TW-1:0];
  localparam [TW-1:0] C_PIPE  = N_PIPE[TW-1:0];

  // Sequencer states
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_ACQ   = 3'd1;
  localparam [2:0] S_WAIT  = 3'd2;
  localparam [2:0] S_READ  = 3'd3;
  localparam [2:0] S_RDWT  = 3'd4;
  localparam [2:0] S_GAP   = 3'd5;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave and registers

  wire        bwr;
  wire [7:0]  bwa;
  wire [31:0] bwd;
  wire [7:0]  bra;
  reg  [31:0] brd;

  atsh_ahb_slave u_bus (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .wr_o        (bwr),
    .wr_addr_o   (bwa),
    .wr_data_o   (bwd),
    .rd_addr_o   (bra),
    .rd_data_i   (brd)
  );

  reg                         ctl_mode;
  reg [`ATSH_CTRL_RDSEL_W-1:0] ctl_rdsel;
  reg [TW-1:0]                acq_cyc;
  reg [`ATSH_IRQ_W-1:0]       irq_stat;
  reg [`ATSH_IRQ_W-1:0]       irq_mask;
  reg [7:0]                   result;
  reg                         ovf;
  reg [2:0]                   state;
  reg                         start_req;
  reg                         ev_done;
  reg                         ev_ovf;
  reg                         pipe_first;

  wire w_ctrl = bwr && (bwa == `ATSH_REG_CTRL);
  wire busy   = (state != S_IDLE);

  always @* begin
    case (bra)
      `ATSH_REG_CTRL:     brd = {27'h000_0000, ctl_rdsel, 1'b0, ctl_mode, 1'b0};
      `ATSH_REG_STATUS:   brd = {28'h000_0000, ovf, ~eoc_n_i, wr_rdy_i, busy};
      `ATSH_REG_IRQ_STAT: brd = {30'h0000_0000, irq_stat};
      `ATSH_REG_IRQ_MASK: brd = {30'h0000_0000, irq_mask};
      `ATSH_REG_RESULT:   brd = {24'h00_0000, result};
      `ATSH_REG_ACQ:      brd = {{(32-TW){1'b0}}, acq_cyc};
      default:            brd = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_mode  <= 1'b0;
      ctl_rdsel <= `ATSH_RD_INT;
      acq_cyc   <= C_ACQ;
      irq_mask  <= {`ATSH_IRQ_W{1'b0}};
      irq_stat  <= {`ATSH_IRQ_W{1'b0}};
      start_req <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      if (w_ctrl && !busy) begin
        ctl_mode  <= bwd[`ATSH_CTRL_MODE];
        ctl_rdsel <= bwd[`ATSH_CTRL_RDSEL +: `ATSH_CTRL_RDSEL_W];
      end
      // Pulses shorter than the minimum acquisition are raised to the minimum
      if (bwr && bwa == `ATSH_REG_ACQ)
        acq_cyc <= (bwd[TW-1:0] < C_ACQ) ? C_ACQ : bwd[TW-1:0];
      if (bwr && bwa == `ATSH_REG_IRQ_MASK)
        irq_mask <= bwd[`ATSH_IRQ_W-1:0];
      // Set beats clear in the same cycle
      irq_stat <= (irq_stat & ~((bwr && bwa == `ATSH_REG_IRQ_STAT) ?
                  bwd[`ATSH_IRQ_W-1:0] : {`ATSH_IRQ_W{1'b0}}))
                  | {ev_ovf, ev_done};
      irq_o <= |(irq_stat & irq_mask);
      // One start is remembered while busy; further ones merge into it
      if (w_ctrl && bwd[`ATSH_CTRL_START])
        start_req <= 1'b1;
      else if (state == S_IDLE)
        start_req <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  reg          tload;
  reg [TW-1:0] tval;
  wire         tdone;

  // One timer serves acquisition, read delay and the gap
  atsh_pin_timer #(.W(TW)) u_tmr (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (tload),
    .value_i (tval),
    .done_o  (tdone)
  );

  wire ro_mode = ~ctl_mode;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state         <= S_IDLE;
      cs_n_o        <= 1'b1;
      rd_n_o        <= 1'b1;
      mode_o        <= 1'b0;
      wr_rdy_o      <= 1'b1;
      wr_rdy_oe_n_o <= 1'b1;
      tload         <= 1'b0;
      tval          <= {TW{1'b0}};
      result        <= 8'h00;
      ovf           <= 1'b0;
      ev_done       <= 1'b0;
      ev_ovf        <= 1'b0;
      pipe_first    <= 1'b1;
    end else begin
      tload   <= 1'b0;
      ev_done <= 1'b0;
      ev_ovf  <= 1'b0;
      mode_o  <= ctl_mode;
      // Shared pin only driven in write-then-read mode
      wr_rdy_oe_n_o <= ro_mode;
      if (mode_o != ctl_mode)
        pipe_first <= 1'b1;
      case (state)
        S_IDLE: begin
          // Gap timer must have run out, so queued starts keep the setup
          if (start_req && tdone) begin
            cs_n_o <= 1'b0;
            if (ro_mode) begin
              rd_n_o <= 1'b0;
              state  <= S_WAIT;
            end else begin
              wr_rdy_o <= 1'b0;
              if (ctl_rdsel == `ATSH_RD_PIPE)
                rd_n_o <= 1'b0;
              tload <= 1'b1;
              tval  <= acq_cyc;
              state <= S_ACQ;
            end
          end
        end
        S_ACQ: begin
          if (tdone && !tload) begin
            wr_rdy_o <= 1'b1;
            if (ctl_rdsel == `ATSH_RD_PIPE) begin
              rd_n_o <= 1'b1;
              if (!pipe_first) begin
                result <= result_bus_i;
                ev_done <= 1'b1;
              end
              pipe_first <= 1'b0;
              // Select stays low until the flag fell and the setup passed
              tload <= 1'b1;
              tval  <= C_PIPE;
              state <= S_GAP;
            end else begin
              tload <= 1'b1;
              tval  <= (ctl_rdsel == `ATSH_RD_EXT) ? C_EXTRD : C_EOC;
              state <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (ro_mode) begin
            // Ready low while busy, released at end
            if (wr_rdy_i && !eoc_n_i) begin
              state <= S_RDWT;
            end
          end else if (tdone && !tload) begin
            case (ctl_rdsel)
              `ATSH_RD_EXT: begin
                rd_n_o <= 1'b0;
                state  <= S_RDWT;
              end
              `ATSH_RD_ALONE: begin
                rd_n_o <= 1'b0;
                state  <= S_RDWT;
              end
              default: begin
                // Internal timing: read only once the end flag is low
                if (!eoc_n_i) begin
                  rd_n_o <= 1'b0;
                  state  <= S_RDWT;
                end
              end
            endcase
          end
        end
        S_RDWT: begin
          state <= S_READ;
        end
        S_READ: begin
          // Read and select rise together, which clears the end flag
          result  <= result_bus_i;
          ovf     <= overflow_flag_i;
          ev_done <= 1'b1;
          ev_ovf  <= overflow_flag_i;
          rd_n_o  <= 1'b1;
          cs_n_o  <= 1'b1;
          tload   <= 1'b1;
          tval    <= C_GAP;
          state   <= S_GAP;
        end
        S_GAP: begin
          if (tdone && !tload) begin
            cs_n_o <= 1'b1;
            state  <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### test/atsh_host_checker.sv
/*
 * Concurrent checks on the converter host controller pins and bus answer.
 * Assumes binding to atsh_host and a device model behind the pins.
 */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module atsh_host_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic irq_o,
  input wire logic cs_n_o,
  input wire logic rd_n_o,
  input wire logic mode_o,
  input wire logic wr_rdy_o,
  input wire logic wr_rdy_oe_n_o,
  input wire logic wr_rdy_i,
  input wire logic eoc_n_i
);
  // Saturating cycle counters; 12 bits cover every pin figure
  logic [11:0] wr_lo;
  logic [11:0] wr_hi;
  logic [11:0] eoc_gap;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_lo   <= 12'h000;
      wr_hi   <= 12'h000;
      eoc_gap <= 12'hfff;
    end else begin
      wr_lo   <= wr_rdy_o ? 12'h000 : wr_lo + {11'h000, ~&wr_lo};
      wr_hi   <= !wr_rdy_o ? 12'h000 : wr_hi + {11'h000, ~&wr_hi};
      eoc_gap <= $fell(eoc_n_i) ? 12'h000 : eoc_gap + {11'h000, ~&eoc_gap};
    end
  end
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready and okay");
  ro_release_a: assert property (!mode_o |-> wr_rdy_oe_n_o)
    else $error("shared pin driven in read-only mode");
  ro_wait_a: assert property (!mode_o && !rd_n_o && !(wr_rdy_i && !eoc_n_i) |=> !rd_n_o)
    else $error("read strobe released before result");
  ro_done_a: assert property (!mode_o && !rd_n_o && wr_rdy_i && !eoc_n_i |-> ##[1:8] rd_n_o)
    else $error("read strobe not released after result");
  acq_width_a: assert property ($rose(wr_rdy_o) && !wr_rdy_oe_n_o |-> wr_lo >= 12'h096)
    else $error("write pulse shorter than acquisition");
  ext_gap_a: assert property ($fell(rd_n_o) && mode_o && wr_rdy_o |-> wr_hi >= 12'h096)
    else $error("read strobe too soon after write rise");
  start_gap_a: assert property ($fell(wr_rdy_o) && !wr_rdy_oe_n_o |-> eoc_gap >= 12'h07d)
    else $error("next write too soon after end flag");
  strobe_sel_a: assert property (!rd_n_o || (!wr_rdy_o && !wr_rdy_oe_n_o) |-> !cs_n_o)
    else $error("strobe low without chip select");
  mode_steady_a: assert property ((!cs_n_o)[*3] |-> $stable(mode_o))
    else $error("mode pin moved during conversion");
  ro_conv_c: cover property ($fell(rd_n_o) && !mode_o);
  wr_conv_c: cover property ($rose(wr_rdy_o) && mode_o);
  pipe_c: cover property ($fell(wr_rdy_o) && $fell(rd_n_o));
  irq_c: cover property ($rose(irq_o));
endmodule
bind atsh_host atsh_host_checker i_chk (.clk_i, .rst_n_i, .hreadyout_o, .hresp_o, .irq_o,
  .cs_n_o, .rd_n_o, .mode_o, .wr_rdy_o, .wr_rdy_oe_n_o, .wr_rdy_i, .eoc_n_i);
`default_nettype wire

// ### test/atsh_adc_model.sv
/*
 * Behavioural two-step converter seen from its pins.
 * Assumes pins change just after clk_i edges; clk_i is only a time base.
 */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module atsh_adc_model #(
  parameter int RO_CYC  = 400,
  parameter int EOC_CYC = 175,
  parameter int EXT_CYC = 150
) (
  // Pins from the host
  input  wire logic       clk_i,
  input  wire logic       cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       mode_i,
  input  wire logic       wr_i,
  // Analog stand-ins
  input  wire logic [7:0] sample_i,
  input  wire logic       ovf_i,
  // Device outputs
  output logic            rdy_pull_o,
  output logic            eoc_n_o,
  output logic            overflow_flag_o,
  output logic      [7:0] result_bus_o
);
  logic        busy = 1'b0;
  logic        rd_q = 1'b1;
  logic        wr_q = 1'b1;
  logic        cs_q = 1'b1;
  logic [11:0] cnt  = 12'h000;
  logic  [7:0] word = 8'h00;
  logic  [7:0] held = 8'h00;
  // Floating mode pin reads low
  wire         md   = (mode_i === 1'b1);
  // Small slack on early read covers pin synchronisation
  wire         fin  = busy && (md ? (cnt == EOC_CYC || (!rd_n_i && cnt >= EXT_CYC - 2))
                                  : cnt == RO_CYC);
  // Released bus shows the inverse, never the last word
  assign result_bus_o = (!cs_n_i && !rd_n_i) ? word : ~word;
  initial begin
    rdy_pull_o      = 1'b0;
    eoc_n_o         = 1'b1;
    overflow_flag_o = 1'b0;
  end
  always @(posedge clk_i) begin
    rd_q <= rd_n_i;
    wr_q <= wr_i;
    cs_q <= cs_n_i;
    cnt  <= busy ? cnt + 12'h001 : 12'h000;
    if ((rd_n_i && !rd_q) || (cs_n_i && !cs_q))
      eoc_n_o <= 1'b1;
    if (!cs_n_i && !md && cs_q)
      rdy_pull_o <= 1'b1;
    if (!cs_n_i && !md && rd_q && !rd_n_i) begin
      busy <= 1'b1;
      held <= sample_i;
    end
    // Tracks from the write fall, holds at its rise
    if (!cs_n_i && md && !wr_q && wr_i) begin
      busy      <= 1'b1;
      held      <= sample_i;
      word[7:4] <= sample_i[7:4];
    end
    if (fin) begin
      busy            <= 1'b0;
      word            <= held;
      eoc_n_o         <= 1'b0;
      rdy_pull_o      <= 1'b0;
      overflow_flag_o <= ovf_i;
    end
  end
endmodule
`default_nettype wire

// ### test/tb_adc_two_step_host_interface.sv
/*
 * Self-checking bench: AHB-Lite master, converter model, queued read checks.
 * Assumes atsh_host, its constants header and the converter model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "atsh_consts.vh"
////////////////////////////////////////////////////////////////////////
module tb_adc_two_step_host_interface;
  logic        clk_i    = 1'b0;
  logic        rst_n_i  = 1'b0;
  logic        hsel_i   = 1'b1;
  logic [31:0] haddr_i  = 32'h0;
  logic  [1:0] htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic  [2:0] hsize_i  = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic  [7:0] sample   = 8'h00;
  logic        ovf      = 1'b0;
  logic        rd_dp    = 1'b0;
  logic [63:0] exp_e;
  logic [63:0] exp_q[$];
  logic  [1:0] style[6] = '{`ATSH_RD_INT, `ATSH_RD_INT, `ATSH_RD_EXT,
                            `ATSH_RD_PIPE, `ATSH_RD_PIPE, `ATSH_RD_ALONE};
  int          err_count = 0;
  int          checked   = 0;
  int          seed      = 82;
  wire  [31:0] hrdata_o;
  wire   [7:0] bus8;
  wire         hreadyout_o, hresp_o, irq_o, cs_n_o, rd_n_o, mode_o;
  wire         wr_rdy_o, wr_rdy_oe_n_o, eoc_n, ovf_pin, rdy_pull;
  // Board pull-up holds a released shared pin high
  wire         pin = !wr_rdy_oe_n_o ? wr_rdy_o : !rdy_pull;

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  atsh_host #(.TW(12)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o), .cs_n_o(cs_n_o),
    .rd_n_o(rd_n_o), .mode_o(mode_o), .wr_rdy_o(wr_rdy_o), .wr_rdy_oe_n_o(wr_rdy_oe_n_o),
    .wr_rdy_i(pin), .eoc_n_i(eoc_n), .overflow_flag_i(ovf_pin), .result_bus_i(bus8));
  atsh_adc_model i_adc (.clk_i(clk_i), .cs_n_i(cs_n_o), .rd_n_i(rd_n_o), .mode_i(mode_o),
    .wr_i(pin), .sample_i(sample), .ovf_i(ovf), .rdy_pull_o(rdy_pull), .eoc_n_o(eoc_n),
    .overflow_flag_o(ovf_pin), .result_bus_o(bus8));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single word transfer; a read notes its masked expectation
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    haddr_i  <= {24'h00_0000, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rd_dp    <= !w;
    if (!w) exp_q.push_back({m, d});
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    rd_dp    <= 1'b0;
  endtask

  // Read data taken at the edge that ends the data phase
  always @(posedge clk_i) begin
    if (rd_dp) begin
      exp_e = exp_q.pop_front();
      chk("hrdata", hrdata_o & exp_e[63:32], exp_e[31:0]);
    end
  end

  task automatic wait_irq;
    int n;
    for (n = 0; n < 3000 && irq_o !== 1'b1; n++) @(negedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h1);
    @(posedge clk_i);
  endtask

  // Priming pipelined conversion hands over no word and raises no done
  task automatic wait_cs;
    int n;
    for (n = 0; n < 3000 && cs_n_o !== 1'b0; n++) @(negedge clk_i);
    for (n = 0; n < 3000 && cs_n_o !== 1'b1; n++) @(negedge clk_i);
    chk("prime end", {31'h0, cs_n_o}, 32'h1);
    chk("prime irq", {31'h0, irq_o}, 32'h0);
    @(posedge clk_i);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #160_000;
    err_count++;
    tally_and_finish;
  end

  initial begin
    logic  [7:0] prev;
    logic [31:0] ctrl;
    int          i;
    prev = 8'h00;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(0, `ATSH_REG_CTRL, `ATSH_CTRL_RESET, 32'hffff_ffff);
    bus(0, `ATSH_REG_ACQ, 32'h96, 32'hffff_ffff);
    bus(1, 8'h18, 32'hffff_ffff, 32'h0);
    bus(0, 8'h18, 32'h0, 32'hffff_ffff);
    bus(1, `ATSH_REG_IRQ_MASK, 32'h1, 32'h0);
    for (i = 0; i < 6; i++) begin
      sample <= $random(seed);
      ovf    <= (i == 5);
      ctrl = {27'h000_0000, style[i], 1'b0, i > 0, 1'b1};
      bus(1, `ATSH_REG_CTRL, ctrl, 32'h0);
      bus(0, `ATSH_REG_CTRL, ctrl & 32'h0000_001e, 32'hffff_ffff);
      if (i == 3)
        wait_cs;
      else
        wait_irq;
      if (i != 3)
        bus(0, `ATSH_REG_RESULT, {24'h0, (style[i] == `ATSH_RD_PIPE) ? prev : sample},
            32'hff);
      if (i == 0) begin
        bus(1, `ATSH_REG_IRQ_MASK, 32'h0, 32'h0);
        repeat (2) @(negedge clk_i);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        @(posedge clk_i);
        bus(1, `ATSH_REG_IRQ_MASK, 32'h1, 32'h0);
      end
      bus(0, `ATSH_REG_IRQ_STAT, {30'h0, i == 5, i != 3}, 32'h3);
      // Still busy inside the gap, except after the priming conversion
      bus(0, `ATSH_REG_STATUS, {28'h0, i == 5, 2'h0, i != 3}, 32'h9);
      bus(1, `ATSH_REG_IRQ_STAT, 32'h3, 32'h0);
      bus(0, `ATSH_REG_IRQ_STAT, 32'h0, 32'h3);
      chk("irq cleared", {31'h0, irq_o}, 32'h0);
      // Mode and style writes are refused while busy: let the gap run out
      repeat (`ATSH_CYC_MIN(`ATSH_T_EOC_NS + `ATSH_T_GAP_NS) + 8) @(posedge clk_i);
      bus(0, `ATSH_REG_STATUS, 32'h0, 32'h1);
      prev = sample;
      $display("pass %0d style %0d done", i, style[i]);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
